// [rtl/urmf_pkg.sv]
// Package with constants and types for the receiver with multi-processor filter.
package urmf_pkg;

  // ==========================================================================
  // Sampling constants
  // ==========================================================================
  localparam logic [4:0] URMF_SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] URMF_SAMPLES_DOUBLE = 5'h08;
  localparam logic [4:0] URMF_FIRST_NORMAL   = 5'h08;
  localparam logic [4:0] URMF_FIRST_DOUBLE   = 5'h04;
  localparam logic [4:0] URMF_MID_NORMAL     = 5'h09;
  localparam logic [4:0] URMF_MID_DOUBLE     = 5'h05;
  localparam logic [4:0] URMF_SAMPLE_RESET   = 5'h01;

  // ==========================================================================
  // Character size codes
  // ==========================================================================
  localparam logic [2:0] URMF_CSZ_5BIT = 3'h0;
  localparam logic [2:0] URMF_CSZ_6BIT = 3'h1;
  localparam logic [2:0] URMF_CSZ_7BIT = 3'h2;
  localparam logic [2:0] URMF_CSZ_8BIT = 3'h3;
  localparam logic [2:0] URMF_CSZ_9BIT = 3'h7;
  localparam logic [3:0] URMF_BITS_5   = 4'h5;
  localparam logic [3:0] URMF_BITS_9   = 4'h9;
  localparam logic [3:0] URMF_BIT_ZERO = 4'h0;

  // ==========================================================================
  // Reset values and divider
  // ==========================================================================
  localparam logic [2:0]  URMF_CSZ_RESET     = 3'h3;
  localparam logic [11:0] URMF_BAUD_DIV_ZERO = 12'h000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       double_speed_select;
    logic       multiproc_filter_enable;
    logic       parity_enable;
    logic       parity_odd;
    logic [2:0] char_size_select;
    logic       rx_enable;
  } urmf_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       rx_ninth_bit;
    logic       frame_error_flag;
    logic       parity_error;
  } urmf_frame_t;

  typedef enum logic [2:0] {
    URMF_IDLE   = 3'b000,
    URMF_START  = 3'b001,
    URMF_DATA   = 3'b010,
    URMF_PARITY = 3'b011,
    URMF_STOP   = 3'b100
  } urmf_state_t;

  function automatic logic urmf_majority(input logic [2:0] s);
    urmf_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

endpackage

// [rtl/urmf_sample_div.sv]
// Divider that makes the oversampling enable pulse from the baud divisor.
`timescale 1ns/10ps
module urmf_sample_div #(
  parameter int DIV_W = 12
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [DIV_W-1:0] baud_divisor,
  output logic                  sample_en
);
  import urmf_pkg::*;

  logic [DIV_W-1:0] cnt_q;

  // ==========================================================================
  // Counter
  // ==========================================================================
  // A divisor of zero gives a pulse every cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      sample_en <= 1'b0;
    end else if (cnt_q == '0) begin
      cnt_q     <= baud_divisor;
      sample_en <= 1'b1;
    end else begin
      cnt_q     <= cnt_q - 1'b1;
      sample_en <= 1'b0;
    end
  end

endmodule

// [rtl/urmf_rx_buffer.sv]
// Two-entry receive buffer with status for the frame at its head.
`timescale 1ns/10ps
module urmf_rx_buffer (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  flush,
  input  wire logic                  push,
  input  wire urmf_pkg::urmf_frame_t push_frame,
  input  wire logic                  pop,
  output urmf_pkg::urmf_frame_t      head_frame,
  output logic                       full,
  output logic                       not_empty
);
  import urmf_pkg::*;

  urmf_frame_t mem_q [2];
  logic        rd_q;
  logic        wr_q;
  logic [1:0]  cnt_q;
  logic        do_push;
  logic        do_pop;

  assign do_pop     = pop && (cnt_q != 2'h0);
  assign do_push    = push && ((cnt_q != 2'h2) || do_pop);
  assign head_frame = mem_q[rd_q];
  assign full       = (cnt_q == 2'h2);
  assign not_empty  = (cnt_q != 2'h0);

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (do_push) begin
      mem_q[wr_q] <= push_frame;
    end
  end

  // ==========================================================================
  // Pointers and fill level
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      rd_q  <= rd_q ^ do_pop;
      wr_q  <= wr_q ^ do_push;
      cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

endmodule

// [rtl/urmf_rx.sv]
// Asynchronous receiver with majority sampling and multi-processor frame filter.
// Summary of operation
// RULE_01: Stop bit resolved by three-sample vote; a zero sets the frame error flag.
// RULE_02: Watch for a new start edge right after the stop bit's last vote sample.
// RULE_03: Sixteen samples per bit normally, eight in double speed mode.
// RULE_04: First vote sample is 8 normally and 4 in double speed mode.
// RULE_05: Middle vote sample is 9 normally and 5 in double speed mode.
// RULE_06: With the filter enabled, data-type frames are dropped, never buffered.
// RULE_07: Frame type bit is first stop bit, or the ninth bit for nine-bit frames.
// RULE_08: Frame type one means address frame, zero means data frame.
// RULE_09: The filter acts on received frames only, never on the transmitter.
// RULE_10: Master and slaves use the nine-bit character format, size code 7.
// RULE_11: Master sets its ninth bit for address frames, clears it for data.
// RULE_12: Address frames under the filter are stored and raise receive complete.
// RULE_13: A selected slave clears its filter enable to receive following data.
// RULE_14: After its last data frame the slave sets its filter enable again.
// RULE_15: Receiver and transmitter share one character size setting.
// RULE_16: Five to eight bit addressing needs the sender set for two stop bits.
// RULE_17: Software must not touch the filter enable with read-modify-write.
// RULE_18: Each bit is the majority of its three centre samples.
// RULE_19: Only the first stop bit is checked; further stop bits are ignored.
// RULE_20: A dropped data frame changes no complete, error, overrun or parity status (its start edge with the buffer full still sets pending overrun).
`timescale 1ns/10ps
module urmf_rx #(
  parameter int DIV_W = 12
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                rx_line,
  input  wire logic [DIV_W-1:0]    baud_divisor,
  input  wire urmf_pkg::urmf_cfg_t cfg,
  input  wire logic                data_read,
  output logic [7:0]               serial_data_register,
  output logic                     rx_ninth_bit,
  output logic                     rx_complete_flag,
  output logic                     frame_error_flag,
  output logic                     overrun_flag,
  output logic                     parity_error_flag,
  output logic [2:0]               tx_char_size_select,
  output logic                     address_frame_seen
);
  import urmf_pkg::*;

  logic        sample_en;
  urmf_state_t state_q;
  logic [4:0]  smp_q;
  logic [3:0]  bit_q;
  logic [8:0]  shift_q;
  logic [2:0]  vote_q;
  logic        rx_prev_q;
  logic        par_q;
  logic        par_err_q;
  logic        ovr_pend_q;
  logic        ovr_head_q;
  logic        push_q;
  urmf_frame_t push_frame_q;
  urmf_frame_t head_frame;
  logic        buf_full;
  logic        buf_not_empty;
  logic [4:0]  smp_per_bit;
  logic [4:0]  smp_first;
  logic [4:0]  smp_mid;
  logic [4:0]  smp_last;
  logic [3:0]  n_data;
  logic        nine_bit;
  logic        vote;
  logic        bit_done;
  logic        frame_type;
  logic        keep_frame;
  logic        flush;
  logic        frame_end;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Wraps the sample count back to one after the last sample of a bit period.
  function automatic logic [4:0] next_smp(input logic [4:0] cur, input logic [4:0] last);
    next_smp = (cur == last) ? URMF_SAMPLE_RESET : cur + 5'h01;
  endfunction

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  // RULE_03 samples per bit
  assign smp_per_bit = cfg.double_speed_select ? URMF_SAMPLES_DOUBLE : URMF_SAMPLES_NORMAL;
  // RULE_04 first vote sample
  assign smp_first   = cfg.double_speed_select ? URMF_FIRST_DOUBLE : URMF_FIRST_NORMAL;
  // RULE_05 middle vote sample
  assign smp_mid     = cfg.double_speed_select ? URMF_MID_DOUBLE : URMF_MID_NORMAL;
  assign smp_last    = smp_mid + 5'h01;
  assign nine_bit    = (cfg.char_size_select == URMF_CSZ_9BIT);
  assign n_data      = nine_bit ? URMF_BITS_9 : (URMF_BITS_5 + {1'b0, cfg.char_size_select});
  assign flush       = !cfg.rx_enable;

  // RULE_18 three centre samples vote
  assign vote     = urmf_majority({vote_q[2:1], rx_line});
  assign bit_done = sample_en && (smp_q == smp_last);
  assign frame_end = bit_done && (state_q == URMF_STOP);

  // RULE_07 frame type source
  // RULE_08 one is address
  assign frame_type = nine_bit ? shift_q[8] : vote;
  // RULE_06 data frames dropped under filter
  // RULE_09 transmitter untouched by the filter
  assign keep_frame = !cfg.multiproc_filter_enable || frame_type;

  // RULE_15 shared size setting
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_char_size_select <= URMF_CSZ_RESET;
    end else begin
      tx_char_size_select <= cfg.char_size_select;
    end
  end

  urmf_sample_div #(
    .DIV_W (DIV_W)
  ) u_div (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .baud_divisor (baud_divisor),
    .sample_en    (sample_en)
  );

  // ==========================================================================
  // Vote sample capture
  // ==========================================================================
  // The edge detector starts at the idle level, so leaving reset with the line high never fakes a start edge.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_prev_q <= 1'b1;
    end else if (sample_en) begin
      rx_prev_q <= rx_line;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vote_q <= 3'h0;
    end else if (sample_en) begin
      if (smp_q == smp_first) begin
        vote_q[2] <= rx_line;
      end
      if (smp_q == smp_mid) begin
        vote_q[1] <= rx_line;
      end
    end
  end

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  // The sample counter restarts on the falling edge, so sample 1 is the first low sample.
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      state_q   <= URMF_IDLE;
      smp_q     <= URMF_SAMPLE_RESET;
      bit_q     <= URMF_BIT_ZERO;
      shift_q   <= 9'h000;
      par_q     <= 1'b0;
      par_err_q <= 1'b0;
    end else if (sample_en) begin
      unique case (state_q)
        URMF_IDLE: begin
          smp_q <= URMF_SAMPLE_RESET;
          if (rx_prev_q && !rx_line) begin
            state_q <= URMF_START;
            smp_q   <= URMF_SAMPLE_RESET + 5'h01;
          end
        end
        URMF_START: begin
          smp_q <= next_smp(smp_q, smp_per_bit);
          if (bit_done) begin
            state_q <= vote ? URMF_IDLE : URMF_START;
          end
          if (smp_q == smp_per_bit) begin
            state_q <= URMF_DATA;
            bit_q   <= URMF_BIT_ZERO;
            par_q   <= cfg.parity_odd;
          end
        end
        URMF_DATA: begin
          smp_q <= next_smp(smp_q, smp_per_bit);
          if (bit_done) begin
            shift_q <= {vote, shift_q[8:1]};
            par_q   <= par_q ^ vote;
          end
          if (smp_q == smp_per_bit) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == n_data - 4'h1) begin
              state_q <= cfg.parity_enable ? URMF_PARITY : URMF_STOP;
            end
          end
        end
        URMF_PARITY: begin
          smp_q <= next_smp(smp_q, smp_per_bit);
          if (bit_done) begin
            par_err_q <= par_q ^ vote;
          end
          if (smp_q == smp_per_bit) begin
            state_q <= URMF_STOP;
          end
        end
        URMF_STOP: begin
          smp_q <= smp_q + 5'h01;
          // RULE_02 early start acceptance
          // RULE_19 first stop bit only
          if (bit_done) begin
            state_q <= URMF_IDLE;
            smp_q   <= URMF_SAMPLE_RESET;
          end
        end
        default: begin
          state_q <= URMF_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Frame completion and filter
  // ==========================================================================
  // Right-align short characters so upper unused bits read as zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      push_q       <= 1'b0;
      push_frame_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (frame_end && keep_frame) begin
        // RULE_12 address frame stored
        push_q                        <= 1'b1;
        push_frame_q.data             <= 8'(shift_q >> (4'h9 - n_data));
        push_frame_q.rx_ninth_bit     <= nine_bit & shift_q[8];
        // RULE_01 stop zero flags error
        push_frame_q.frame_error_flag <= !vote;
        push_frame_q.parity_error     <= cfg.parity_enable & par_err_q;
      end
    end
  end

  // Overrun is noticed at the start edge while the buffer is full and a frame waits.
  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      ovr_pend_q <= 1'b0;
      ovr_head_q <= 1'b0;
    end else begin
      // RULE_20 dropped frames leave complete, error and parity status alone, but not the pending overrun set below
      if (push_q && !(buf_full && !data_read)) begin
        ovr_head_q <= ovr_pend_q;
        ovr_pend_q <= 1'b0;
      end
      // A loss noticed in the cycle of a push must survive it, so the set comes last.
      if (sample_en && (state_q == URMF_IDLE) && rx_prev_q && !rx_line && buf_full) begin
        ovr_pend_q <= 1'b1;
      end
    end
  end

  urmf_rx_buffer u_buf (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .flush      (flush),
    .push       (push_q),
    .push_frame (push_frame_q),
    .pop        (data_read),
    .head_frame (head_frame),
    .full       (buf_full),
    .not_empty  (buf_not_empty)
  );

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serial_data_register <= 8'h00;
      rx_ninth_bit         <= 1'b0;
      rx_complete_flag     <= 1'b0;
    end else begin
      serial_data_register <= buf_not_empty ? head_frame.data : 8'h00;
      rx_ninth_bit         <= buf_not_empty & head_frame.rx_ninth_bit;
      rx_complete_flag     <= buf_not_empty;
    end
  end

  // Error and parity bits belong to the head frame and fall with it; overrun follows the latest push; an empty buffer reads clean.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frame_error_flag  <= 1'b0;
      overrun_flag      <= 1'b0;
      parity_error_flag <= 1'b0;
    end else begin
      frame_error_flag  <= buf_not_empty & head_frame.frame_error_flag;
      parity_error_flag <= buf_not_empty & head_frame.parity_error;
      overrun_flag      <= buf_not_empty & ovr_head_q;
    end
  end

  // The address pulse ignores the filter setting, so it marks every address frame on the line.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      address_frame_seen <= 1'b0;
    end else begin
      address_frame_seen <= frame_end && frame_type;
    end
  end

endmodule

// [tb/urmf_rx_monitor.sv]
// Checker that watches the ports of the receiver with multi-processor filter.
`timescale 1ns/10ps
module urmf_rx_monitor #(
  parameter int DIV_W = 12
) (
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                rx_line,
  input wire logic [DIV_W-1:0]    baud_divisor,
  input wire urmf_pkg::urmf_cfg_t cfg,
  input wire logic                data_read,
  input wire logic [7:0]          serial_data_register,
  input wire logic                rx_ninth_bit,
  input wire logic                rx_complete_flag,
  input wire logic                frame_error_flag,
  input wire logic                overrun_flag,
  input wire logic                parity_error_flag,
  input wire logic [2:0]          tx_char_size_select,
  input wire logic                address_frame_seen
);
  import urmf_pkg::*;
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic [2:0] addr_age_q;
  // Saturates, so a stale address pulse can never excuse a late store.
  always_ff @(posedge core_clk) begin
    if (!rst_n) addr_age_q <= 3'h7;
    else if (address_frame_seen) addr_age_q <= 3'h0;
    else if (addr_age_q != 3'h7) addr_age_q <= addr_age_q + 3'h1;
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_tx_follow;
    $stable(cfg.char_size_select) [*2] |-> tx_char_size_select == cfg.char_size_select;
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("tx size differs from cfg");
  property p_tx_change;
    tx_char_size_select != $past(tx_char_size_select) |-> tx_char_size_select == $past(cfg.char_size_select);
  endproperty
  a_tx_change: assert property (p_tx_change) else $error("tx size changed on its own");
  property p_empty_quiet;
    !rx_complete_flag |-> !frame_error_flag && !overrun_flag && !parity_error_flag && !rx_ninth_bit;
  endproperty
  a_empty_quiet: assert property (p_empty_quiet) else $error("status set with empty buffer");
  property p_empty_zero;
    !rx_complete_flag |-> serial_data_register == 8'h00;
  endproperty
  a_empty_zero: assert property (p_empty_zero) else $error("data nonzero with empty buffer");
  property p_addr_spacing;
    address_frame_seen |=> !address_frame_seen [*8];
  endproperty
  a_addr_spacing: assert property (p_addr_spacing) else $error("address pulse too long");
  property p_filter_addr;
    $rose(rx_complete_flag) && cfg.multiproc_filter_enable |-> address_frame_seen || addr_age_q < 3'h5;
  endproperty
  a_filter_addr: assert property (p_filter_addr) else $error("non-address frame stored");
  property p_rxc_holds;
    rx_complete_flag && cfg.rx_enable && !data_read && !$past(data_read) |=> rx_complete_flag;
  endproperty
  a_rxc_holds: assert property (p_rxc_holds) else $error("complete flag dropped unread");
  property p_head_stable;
    rx_complete_flag && $past(rx_complete_flag) && !$past(data_read) && !$past(data_read, 2) && $past(cfg.rx_enable)
      |-> $stable({serial_data_register, rx_ninth_bit, frame_error_flag});
  endproperty
  a_head_stable: assert property (p_head_stable) else $error("head frame changed unread");
  c_addr_filtered: cover property (cfg.multiproc_filter_enable && $rose(rx_complete_flag));
  c_frame_error: cover property ($rose(frame_error_flag));
  c_double: cover property (cfg.double_speed_select && $rose(rx_complete_flag));
endmodule

// [tb/urmf_line_model.sv]
// Remote serial transmitter that drives the receive line.
`timescale 1ns/10ps
module urmf_line_model (
  input  wire logic core_clk,
  output logic      rx_line
);
  // The line idles high between frames, as a pulled-up bus does.
  initial rx_line = 1'b1;
  task automatic hold(input logic v, input int n);
    rx_line = v;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic send_frame(input logic [8:0] d, input int nb, input logic stop1, input int s1, input int s2,
                            input int bc);
    hold(1'b0, bc);
    for (int i = 0; i < nb; i++) hold(d[i], bc);
    hold(stop1, s1);
    if (s2 > 0) hold(1'b1, s2);
  endtask
endmodule

// [tb/uart_rx_multiproc_filter_tb_top.sv]
// Self-checking testbench of the receiver with multi-processor filter.
`timescale 1ns/10ps
module uart_rx_multiproc_filter_tb_top;
  import urmf_pkg::*;
  localparam int DIV_W = 12;
  logic              core_clk;
  logic              rst_n;
  logic              rx_line;
  logic [DIV_W-1:0]  baud_divisor;
  urmf_cfg_t         cfg;
  logic              data_read;
  logic [7:0]        serial_data_register;
  logic              rx_ninth_bit;
  logic              rx_complete_flag;
  logic              frame_error_flag;
  logic              overrun_flag;
  logic              parity_error_flag;
  logic [2:0]        tx_char_size_select;
  logic              address_frame_seen;
  int                mismatches;
  int                checks;
  int                bc;
  urmf_frame_t       exp_q[$];
  urmf_rx #(.DIV_W(DIV_W)) urmf_rx_i (.core_clk, .rst_n, .rx_line, .baud_divisor, .cfg, .data_read,
    .serial_data_register, .rx_ninth_bit, .rx_complete_flag, .frame_error_flag, .overrun_flag,
    .parity_error_flag, .tx_char_size_select, .address_frame_seen);
  urmf_line_model urmf_line_model_i (.core_clk, .rx_line);
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_frame(input urmf_frame_t e);
    urmf_frame_t got;
    got = {serial_data_register, rx_ninth_bit, frame_error_flag, parity_error_flag};
    checks++;
    if (got !== e) begin
      mismatches++;
      $display("CHECK FAILED frame expected %h seen %h", e, got);
    end
  endtask
  task automatic check_val(input string name, input logic [7:0] e, input logic [7:0] got);
    checks++;
    if (got !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic set_cfg(input logic ds, input logic mp, input logic [2:0] csz);
    cfg = '{ds, mp, 1'b0, 1'b0, csz, 1'b1};
    bc = (ds ? 8 : 16) * (int'(baud_divisor) + 1);
  endtask
  task automatic send(input logic [8:0] d, input int nb, input logic stop1, input int s1, input int s2,
                      input logic keep);
    urmf_frame_t e;
    e.data = d[7:0] & ((nb > 8) ? 8'hff : (8'hff >> (8 - nb)));
    e.rx_ninth_bit = (nb == 9) ? d[8] : 1'b0;
    e.frame_error_flag = ~stop1;
    e.parity_error = 1'b0;
    if (keep) exp_q.push_back(e);
    urmf_line_model_i.send_frame(d, nb, stop1, s1, s2, bc);
  endtask
  task automatic drain(input string name);
    int n = 0;
    while ((exp_q.size() != 0 || rx_complete_flag !== 1'b0) && n < 5000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 5000) begin
      mismatches++;
      $display("CHECK FAILED drain_%s expected empty seen %0d", name, exp_q.size());
      finish_test();
    end
    check_val("tx_size", {5'h00, cfg.char_size_select}, {5'h00, tx_char_size_select});
    $display("test %s done", name);
  endtask
  // ==========================================================================
  // Result watcher
  // ==========================================================================
  initial begin
    data_read = 1'b0;
    forever begin
      @(posedge core_clk);
      #1;
      if (rx_complete_flag === 1'b1) begin
        if (exp_q.size() == 0) begin
          checks++;
          mismatches++;
          $display("CHECK FAILED unexpected_frame expected none seen %h", serial_data_register);
        end else check_frame(exp_q.pop_front());
        check_val("overrun", 8'h00, {7'h00, overrun_flag});
        data_read = 1'b1;
        @(posedge core_clk);
        #1;
        data_read = 1'b0;
        @(posedge core_clk);
      end
    end
  end
  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    baud_divisor = 12'h001;
    set_cfg(1'b0, 1'b0, URMF_CSZ_8BIT);
    void'($urandom(32'hdbb8));
    repeat (16) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    send(9'($urandom), 8, 1'b1, bc, 2 * bc, 1'b1);
    send(9'($urandom), 8, 1'b0, bc, 2 * bc, 1'b1);
    // short stop, next start at once
    send(9'($urandom), 8, 1'b1, 12 * (int'(baud_divisor) + 1), 0, 1'b1);
    send(9'($urandom), 8, 1'b1, bc, 2 * bc, 1'b1);
    drain("normal");
    set_cfg(1'b1, 1'b0, URMF_CSZ_8BIT);
    send(9'($urandom), 8, 1'b1, bc, 2 * bc, 1'b1);
    send(9'($urandom), 8, 1'b0, bc, 2 * bc, 1'b1);
    drain("double");
    set_cfg(1'b0, 1'b1, URMF_CSZ_9BIT);
    send({1'b0, 8'($urandom)}, 9, 1'b1, bc, 2 * bc, 1'b0);
    send({1'b0, 8'($urandom)}, 9, 1'b0, bc, 2 * bc, 1'b0);
    send({1'b1, 8'($urandom)}, 9, 1'b1, bc, 2 * bc, 1'b1);
    drain("nine_address");
    set_cfg(1'b0, 1'b0, URMF_CSZ_9BIT);
    send({1'b0, 8'($urandom)}, 9, 1'b1, bc, 2 * bc, 1'b1);
    drain("nine_selected");
    // filter set again after the last data frame
    set_cfg(1'b0, 1'b1, URMF_CSZ_9BIT);
    send({1'b0, 8'($urandom)}, 9, 1'b1, bc, 2 * bc, 1'b0);
    send({1'b1, 8'($urandom)}, 9, 1'b1, bc, 2 * bc, 1'b1);
    drain("nine_reselect");
    // short characters, first stop carries the frame type
    for (int c = 0; c < 4; c++) begin
      set_cfg(1'b0, 1'b1, 3'(c));
      send(9'($urandom), c + 5, 1'b0, bc, 2 * bc, 1'b0);
      send(9'($urandom), c + 5, 1'b1, bc, 2 * bc, 1'b1);
      drain("short_char");
    end
    finish_test();
  end
endmodule
bind urmf_rx urmf_rx_monitor #(.DIV_W(DIV_W)) urmf_rx_monitor_i (.core_clk, .rst_n, .rx_line, .baud_divisor,
  .cfg, .data_read, .serial_data_register, .rx_ninth_bit, .rx_complete_flag, .frame_error_flag, .overrun_flag,
  .parity_error_flag, .tx_char_size_select, .address_frame_seen);
